// file: verilog/isu_exec.sv
// Issue group control and two-stage execute pipeline of the unit.
`timescale 1ns/1ns

module isu_exec #(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic srst_in,
  // Mode.
  input wire logic big_endian_mode_in,
  // Instruction group from decode, slot 0 oldest.
  input wire isu_pkg::isu_slot_t [W-1:0] group_in,
  input wire logic group_valid_in,
  output logic group_ready_out,
  // Issue report.
  output logic [W-1:0] issue_mask_out,
  // Register file write back and exceptions.
  output isu_pkg::isu_res_t [W-1:0] res_out,
  // Translation port.
  output isu_pkg::isu_xreq_t [W-1:0] xlat_req_out,
  input wire isu_pkg::isu_xrsp_t [W-1:0] xlat_rsp_in,
  // Memory write port.
  output isu_pkg::isu_mem_t [W-1:0] mem_out
);
  import isu_pkg::*;

  localparam int CW = $clog2(W + 1);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (W < 1 || W > 8)
  begin : g_bad_width
    $error("Issue width must lie between one and eight.");
  end

  // ****************************************************************
  // Group helpers
  // ****************************************************************
  // Length of the leading group that may issue together.
  function automatic logic [CW-1:0] group_len(
    input isu_slot_t [W-1:0] s
  );
    logic [CW-1:0] n;
    logic stop;
    n = '0;
    stop = 1'b0;
    for (int i = 0; i < W; i++)
    begin
      if (!stop && s[i].valid)
      begin
        if (isu_decode(s[i].instr) == OP_SSNOP)
        begin
          if (i == 0)
            n = CW'(1);
          stop = 1'b1;
        end
        else
          n = CW'(i + 1);
      end
      else
        stop = 1'b1;
    end
    return n;
  endfunction : group_len

  // Number of valid slots held.
  function automatic logic [CW-1:0] valid_cnt(
    input isu_slot_t [W-1:0] s
  );
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < W; i++)
    begin
      if (s[i].valid)
        n = n + CW'(1);
    end
    return n;
  endfunction : valid_cnt

  // ****************************************************************
  // Issue control
  // ****************************************************************
  isu_slot_t [W-1:0] hold;
  isu_slot_t [W-1:0] shifted_hold;
  isu_slot_t [W-1:0] next_hold;
  logic [CW-1:0] issue_len;
  logic [W-1:0] issue_en;
  logic load;
  logic next_ready;

  always_comb
  begin
    issue_len = group_len(hold);
    for (int i = 0; i < W; i++)
    begin
      issue_en[i] = (CW'(i) < issue_len);
      shifted_hold[i] = '0;
      if (i + int'(issue_len) < W)
        shifted_hold[i] = hold[i + int'(issue_len)];
    end
    load = group_ready_out && group_valid_in;
    next_hold = load ? group_in : shifted_hold;
    // Ready only when the next held group leaves nothing behind.
    next_ready = (group_len(next_hold) == valid_cnt(next_hold));
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      hold <= '0;
      group_ready_out <= 1'b1;
      issue_mask_out <= '0;
    end
    else
    begin
      hold <= next_hold;
      group_ready_out <= next_ready;
      issue_mask_out <= issue_en;
    end
  end

  // ****************************************************************
  // Execute lanes
  // ****************************************************************
  isu_lane_t e_lane [W];

  for (genvar g = 0; g < W; g++)
  begin : g_lane
    isu_slot_t lane_slot;
    assign lane_slot = issue_en[g] ? hold[g] : '0;
    isu_lane i_isu_lane (
      .slot_in(lane_slot),
      .big_endian_mode_in(big_endian_mode_in),
      .lane_out(e_lane[g])
    );
  end

  // ****************************************************************
  // Translate stage
  // ****************************************************************
  isu_lane_t m_lane [W];
  logic [W-1:0] m_valid;
  logic [4:0] m_dst [W];

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      m_valid <= '0;
      xlat_req_out <= '0;
      for (int i = 0; i < W; i++)
      begin
        m_lane[i] <= '0;
        m_dst[i] <= '0;
      end
    end
    else
    begin
      m_valid <= issue_en;
      for (int i = 0; i < W; i++)
      begin
        m_lane[i] <= e_lane[i];
        m_dst[i] <= hold[i].instr.dst_field;
        xlat_req_out[i].valid <= e_lane[i].st;
        xlat_req_out[i].vaddr <= e_lane[i].vaddr;
      end
    end
  end

  // ****************************************************************
  // Commit stage
  // ****************************************************************
  isu_exc_t c_exc [W];

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      c_exc[i] = m_lane[i].exc;
      if (m_lane[i].st)
      begin
        if (xlat_rsp_in[i].refill)
          c_exc[i] = EXC_REFILL;
        else if (xlat_rsp_in[i].invalid)
          c_exc[i] = EXC_INVALID;
        else if (xlat_rsp_in[i].modified)
          c_exc[i] = EXC_MODIFIED;
        else if (xlat_rsp_in[i].watch)
          c_exc[i] = EXC_WATCH;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      res_out <= '0;
      mem_out <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        res_out[i].valid <= m_valid[i];
        res_out[i].wr_en <= m_valid[i] && m_lane[i].wr_en;
        res_out[i].dst <= m_dst[i];
        res_out[i].data <= m_lane[i].data;
        res_out[i].exc <= m_valid[i] ? c_exc[i] : EXC_NONE;
        mem_out[i].wr <= m_valid[i] && m_lane[i].st &&
                         c_exc[i] == EXC_NONE;
        mem_out[i].vaddr <= m_lane[i].vaddr;
        mem_out[i].data <= m_lane[i].st_data;
        mem_out[i].be <= m_lane[i].be;
      end
    end
  end

  // ****************************************************************
  // Checks on lane 0, except the SSNOP issue checks, which cover every lane
  // ****************************************************************
  localparam int WW = `ISU_WORD_W;
  localparam int XW = `ISU_XLEN;

  isu_op_t chk_op;
  logic [WW-1:0] chk_sh;
  logic [XW-1:0] chk_srl;
  logic [WW:0] chk_diff;
  logic [XW-1:0] chk_sub;
  logic chk_ovf;
  logic [XW-1:0] chk_ea;
  logic chk_late_ssnop;
  logic chk_follow;

  always_comb
  begin
    chk_op = issue_en[0] ? isu_decode(hold[0].instr) : OP_OTHER;
    chk_sh = hold[0].opb[WW-1:0] >> hold[0].opa[`ISU_SHCNT_W-1:0];
    chk_srl = {{(XW-WW){chk_sh[WW-1]}}, chk_sh};
    chk_diff = {hold[0].opa[WW-1], hold[0].opa[WW-1:0]} -
               {hold[0].opb[WW-1], hold[0].opb[WW-1:0]};
    chk_ovf = chk_diff[WW] ^ chk_diff[WW-1];
    chk_sub = {{(XW-WW){chk_diff[WW-1]}}, chk_diff[WW-1:0]};
    chk_ea = hold[0].opa + {{(XW-`ISU_IMM_W){hold[0].instr.dst_field[4]}},
      hold[0].instr.dst_field, hold[0].instr.shamt, hold[0].instr.funct};
    chk_late_ssnop = 1'b0;
    chk_follow = 1'b0;
    for (int i = 1; i < W; i++)
    begin
      if (issue_en[i] && isu_decode(hold[i].instr) == OP_SSNOP)
        chk_late_ssnop = 1'b1;
      if (i == 1 && hold[i].valid)
        chk_follow = 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  AST_SHR_RESULT: assert property (
    chk_op == OP_SHR_VAR |-> ##2
      (res_out[0].wr_en && res_out[0].data == $past(chk_srl, 2)))
    else $error("Shift result does not match its operands.");

  AST_NO_TRAP_OPS: assert property (
    (chk_op == OP_SHR_VAR || chk_op == OP_SUB_MOD) |-> ##2
      res_out[0].exc == EXC_NONE)
    else $error("Shift or modulo subtract raised an exception.");

  AST_SUB_OVERFLOW: assert property (
    (chk_op == OP_SUB && chk_ovf) |-> ##2
      (res_out[0].exc == EXC_OVERFLOW && !res_out[0].wr_en))
    else $error("Overflowing subtract was not trapped.");

  AST_SUB_RESULT: assert property (
    (chk_op == OP_SUB && !chk_ovf) |-> ##2
      (res_out[0].wr_en && res_out[0].data == $past(chk_sub, 2)))
    else $error("Trapping subtract wrote a wrong result.");

  AST_SUB_MOD_RESULT: assert property (
    chk_op == OP_SUB_MOD |-> ##2
      (res_out[0].wr_en && res_out[0].data == $past(chk_sub, 2)))
    else $error("Modulo subtract wrote a wrong result.");

  AST_STORE_MISALIGN: assert property (
    (chk_op == OP_STORE_W && chk_ea[1:0] != 2'h0) |->
      ##1 !xlat_req_out[0].valid
      ##1 (!mem_out[0].wr && res_out[0].exc == EXC_ADDR))
    else $error("Misaligned store was not refused.");

  AST_STORE_ADDRESS: assert property (
    (chk_op == OP_STORE_W && chk_ea[1:0] == 2'h0) |-> ##1
      (xlat_req_out[0].valid && xlat_req_out[0].vaddr == $past(chk_ea)))
    else $error("Store address wrong or not presented.");

  AST_STORE_LANE: assert property (
    mem_out[0].wr |-> mem_out[0].be ==
      ((mem_out[0].vaddr[`ISU_HALF_BIT] ^ $past(big_endian_mode_in, 2))
        ? `ISU_BE_HI : `ISU_BE_LO))
    else $error("Store word sits in the wrong half.");

  AST_FAULT_NO_WRITE: assert property (
    (xlat_req_out[0].valid && xlat_rsp_in[0] != '0) |=>
      (!mem_out[0].wr && res_out[0].exc != EXC_NONE))
    else $error("Faulting store reached memory.");

  AST_SSNOP_ALONE: assert property (
    (chk_op == OP_SSNOP |=> issue_mask_out == W'(1)) and !chk_late_ssnop)
    else $error("SSNOP shared its issue group.");

  AST_SSNOP_NEXT: assert property (
    (chk_op == OP_SSNOP && chk_follow) |=> issue_en[0])
    else $error("Instruction after SSNOP was stalled.");

  AST_SSNOP_QUIET: assert property (
    chk_op == OP_SSNOP |-> ##2
      (res_out[0].valid && !res_out[0].wr_en &&
       res_out[0].exc == EXC_NONE))
    else $error("SSNOP wrote a register or raised an exception.");

  COV_SHR: cover property (chk_op == OP_SHR_VAR);
  COV_SUB_OVF: cover property (chk_op == OP_SUB && chk_ovf);
  COV_SSNOP_SPLIT: cover property (chk_op == OP_SSNOP && chk_follow);
  COV_STORE: cover property (mem_out[0].wr);

endmodule : isu_exec

// file: shared/isu_map.svh
// Constants of the integer shift, subtract and store unit.
`ifndef ISU_MAP_SVH
`define ISU_MAP_SVH

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define ISU_OPC_SPECIAL 6'h00
`define ISU_OPC_STORE_W 6'h2b
`define ISU_FN_SHL 6'h00
`define ISU_FN_SHR_VAR 6'h06
`define ISU_FN_SUB 6'h22
`define ISU_FN_SUB_MOD 6'h23
`define ISU_SSNOP_SA 5'h01
`define ISU_ZERO_REG 5'h00

// ****************************************************************
// Data path widths, positions and store lanes
// ****************************************************************
`define ISU_XLEN 64
`define ISU_WORD_W 32
`define ISU_IMM_W 16
`define ISU_SHCNT_W 5
`define ISU_ALIGN_MASK 64'h3
`define ISU_BE_XOR 3'h4
`define ISU_HALF_BIT 2
`define ISU_BE_LO 8'h0f
`define ISU_BE_HI 8'hf0

`endif

// file: shared/isu_pkg.sv
// Types shared by the integer shift, subtract and store unit.
`include "isu_map.svh"

package isu_pkg;

  // ****************************************************************
  // Instruction word and decoded operations
  // ****************************************************************
  typedef struct packed {
    logic [5:0] opcode;
    logic [4:0] src_a_field;
    logic [4:0] src_b_field;
    logic [4:0] dst_field;
    logic [4:0] shamt;
    logic [5:0] funct;
  } isu_instr_t;

  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_SHR_VAR = 3'h1,
    OP_SUB = 3'h2,
    OP_SUB_MOD = 3'h3,
    OP_STORE_W = 3'h4,
    OP_SSNOP = 3'h5
  } isu_op_t;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_OVERFLOW = 3'h1,
    EXC_ADDR = 3'h2,
    EXC_REFILL = 3'h3,
    EXC_INVALID = 3'h4,
    EXC_MODIFIED = 3'h5,
    EXC_WATCH = 3'h6
  } isu_exc_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    isu_instr_t instr;
    logic [63:0] opa;
    logic [63:0] opb;
  } isu_slot_t;

  typedef struct packed {
    logic wr_en;
    logic [63:0] data;
    isu_exc_t exc;
    logic st;
    logic [63:0] vaddr;
    logic [63:0] st_data;
    logic [7:0] be;
  } isu_lane_t;

  typedef struct packed {
    logic valid;
    logic wr_en;
    logic [4:0] dst;
    logic [63:0] data;
    isu_exc_t exc;
  } isu_res_t;

  typedef struct packed {
    logic valid;
    logic [63:0] vaddr;
  } isu_xreq_t;

  typedef struct packed {
    logic refill;
    logic invalid;
    logic modified;
    logic watch;
  } isu_xrsp_t;

  typedef struct packed {
    logic wr;
    logic [63:0] vaddr;
    logic [63:0] data;
    logic [7:0] be;
  } isu_mem_t;

  // Maps an instruction word to the operation this unit performs.
  function automatic isu_op_t isu_decode(input isu_instr_t ins);
    isu_op_t op;
    op = OP_OTHER;
    if (ins.opcode == `ISU_OPC_STORE_W)
      op = OP_STORE_W;
    else if (ins.opcode == `ISU_OPC_SPECIAL)
    begin
      case (ins.funct)
        `ISU_FN_SHR_VAR: op = OP_SHR_VAR;
        `ISU_FN_SUB: op = OP_SUB;
        `ISU_FN_SUB_MOD: op = OP_SUB_MOD;
        `ISU_FN_SHL:
        begin
          if (ins.src_a_field == `ISU_ZERO_REG &&
              ins.src_b_field == `ISU_ZERO_REG &&
              ins.dst_field == `ISU_ZERO_REG &&
              ins.shamt == `ISU_SSNOP_SA)
            op = OP_SSNOP;
        end
        default: op = OP_OTHER;
      endcase
    end
    return op;
  endfunction : isu_decode

endpackage : isu_pkg

// file: verilog/isu_lane.sv
// Combinational execute lane: shift, subtracts and store preparation.
`timescale 1ns/1ns

module isu_lane (
  // Issued operation.
  input wire isu_pkg::isu_slot_t slot_in,
  input wire logic big_endian_mode_in,
  // Outcome before translation.
  output isu_pkg::isu_lane_t lane_out
);
  import isu_pkg::*;

  localparam int XW = `ISU_XLEN;
  localparam int WW = `ISU_WORD_W;
  localparam int IW = `ISU_IMM_W;

  isu_op_t op;
  logic [IW-1:0] imm;
  logic [WW-1:0] shifted;
  logic [WW:0] diff;
  logic [XW-1:0] vaddr;
  logic [2:0] bytesel;

  // ****************************************************************
  // Execute
  // ****************************************************************
  always_comb
  begin
    lane_out = '0;
    op = isu_decode(slot_in.instr);
    imm = {slot_in.instr.dst_field, slot_in.instr.shamt,
           slot_in.instr.funct};
    // Only the low words are used, so non-word operands give any value.
    shifted = slot_in.opb[WW-1:0] >>
              slot_in.opa[`ISU_SHCNT_W-1:0];
    diff = {slot_in.opa[WW-1], slot_in.opa[WW-1:0]} -
           {slot_in.opb[WW-1], slot_in.opb[WW-1:0]};
    vaddr = slot_in.opa + {{(XW-IW){imm[IW-1]}}, imm};
    bytesel = vaddr[2:0] ^
              (big_endian_mode_in ? `ISU_BE_XOR : 3'h0);
    case (op)
      OP_SHR_VAR:
      begin
        lane_out.wr_en = 1'b1;
        lane_out.data = {{(XW-WW){shifted[WW-1]}}, shifted};
      end
      OP_SUB:
      begin
        if (diff[WW] != diff[WW-1])
          lane_out.exc = EXC_OVERFLOW;
        else
        begin
          lane_out.wr_en = 1'b1;
          lane_out.data = {{(XW-WW){diff[WW-1]}}, diff[WW-1:0]};
        end
      end
      OP_SUB_MOD:
      begin
        lane_out.wr_en = 1'b1;
        lane_out.data = {{(XW-WW){diff[WW-1]}}, diff[WW-1:0]};
      end
      OP_STORE_W:
      begin
        lane_out.vaddr = vaddr;
        if ((vaddr & `ISU_ALIGN_MASK) != '0)
          lane_out.exc = EXC_ADDR;
        else
        begin
          lane_out.st = 1'b1;
          if (bytesel[`ISU_HALF_BIT])
          begin
            lane_out.st_data = {slot_in.opb[WW-1:0], {WW{1'b0}}};
            lane_out.be = `ISU_BE_HI;
          end
          else
          begin
            lane_out.st_data = {{WW{1'b0}}, slot_in.opb[WW-1:0]};
            lane_out.be = `ISU_BE_LO;
          end
        end
      end
      default: lane_out.exc = EXC_NONE;
    endcase
  end

endmodule : isu_lane

// file: sim/isu_mmu_model.sv
// Behavioural translation port that answers in the cycle of the request.
`timescale 1ns/1ns

module isu_mmu_model #(
  parameter int W = 2
) (
  // Requests from the unit.
  input wire isu_pkg::isu_xreq_t [W-1:0] req_in,
  // Fault pattern chosen by the bench.
  input wire isu_pkg::isu_xrsp_t fault_in,
  // Answers to the unit.
  output isu_pkg::isu_xrsp_t [W-1:0] rsp_out
);
  import isu_pkg::*;

  // Without a request the answer is the inverse, so a stale answer shows.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      rsp_out[i] = req_in[i].valid ? fault_in : ~fault_in;
    end
  end

endmodule : isu_mmu_model

// file: sim/isu_exec_tb.sv
// Self-checking testbench of the integer shift, subtract and store unit.
`timescale 1ns/1ns
`include "isu_map.svh"

module isu_exec_tb;
  import isu_pkg::*;

  logic mclk_in;
  logic srst_in;
  logic big_endian_mode_in;
  isu_slot_t [1:0] group_in;
  logic group_valid_in;
  logic group_ready_out;
  logic [1:0] issue_mask_out;
  isu_res_t [1:0] res_out;
  isu_xreq_t [1:0] xlat_req_out;
  isu_xrsp_t [1:0] xlat_rsp_in;
  isu_mem_t [1:0] mem_out;
  isu_xrsp_t fault;
  int err_total;
  int n_tests;
  isu_res_t res0 [8];
  isu_res_t res1 [8];
  logic [1:0] mk [8];
  isu_mem_t m0 [8];
  isu_mem_t m1 [8];
  isu_xreq_t x0 [8];
  isu_xreq_t x1 [8];
  logic rdy [8];

  isu_exec #(.W(2)) i_isu_exec (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .big_endian_mode_in(big_endian_mode_in),
    .group_in(group_in),
    .group_valid_in(group_valid_in),
    .group_ready_out(group_ready_out),
    .issue_mask_out(issue_mask_out),
    .res_out(res_out),
    .xlat_req_out(xlat_req_out),
    .xlat_rsp_in(xlat_rsp_in),
    .mem_out(mem_out)
  );

  isu_mmu_model #(.W(2)) i_isu_mmu_model (
    .req_in(xlat_req_out),
    .fault_in(fault),
    .rsp_out(xlat_rsp_in)
  );

  always #25 mclk_in = ~mclk_in;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic isu_instr_t alu(input logic [5:0] fn,
                                     input logic [4:0] rd);
    return {`ISU_OPC_SPECIAL, 5'h01, 5'h02, rd, 5'h00, fn};
  endfunction : alu

  function automatic isu_instr_t shl0(input logic [4:0] sa);
    return {`ISU_OPC_SPECIAL, 15'h0000, sa, `ISU_FN_SHL};
  endfunction : shl0

  function automatic isu_instr_t swi(input logic [15:0] imm);
    return {`ISU_OPC_STORE_W, 5'h03, 5'h04, imm};
  endfunction : swi

  function automatic isu_slot_t sl(input isu_instr_t i,
                                   input logic [63:0] a,
                                   input logic [63:0] b);
    return {1'b1, i, a, b};
  endfunction : sl

  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  // Offers one group, then records eight cycles after it is taken.
  task automatic run(input isu_slot_t s0, input isu_slot_t s1);
    int n;
    n = 0;
    @(negedge mclk_in);
    group_in[0] = s0;
    group_in[1] = s1;
    group_valid_in = 1'b1;
    while (group_ready_out !== 1'b1 && n < 20)
    begin
      @(negedge mclk_in);
      n++;
    end
    if (n == 20)
    begin
      $display("MISMATCH group_ready expected 1 seen %b", group_ready_out);
      err_total++;
    end
    @(negedge mclk_in);
    group_valid_in = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rdy[k] = group_ready_out;
      mk[k] = issue_mask_out;
      res0[k] = res_out[0];
      res1[k] = res_out[1];
      m0[k] = mem_out[0];
      m1[k] = mem_out[1];
      x0[k] = xlat_req_out[0];
      x1[k] = xlat_req_out[1];
      @(negedge mclk_in);
    end
  endtask : run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_shift();
    run(sl(alu(`ISU_FN_SHR_VAR, 5'h07), 64'h24, 64'hffff_ffff_8000_0000), '0);
    chk("shr_cnt", 64'h0800_0000, res0[2].data);
    chk("shr_dst", 64'h7, 64'(res0[2].dst));
    chk("shr_exc", 64'(EXC_NONE), 64'(res0[2].exc));
    run(sl(alu(`ISU_FN_SHR_VAR, 5'h07), 64'hffff_ffff_ffff_ffe0,
           64'hffff_ffff_8000_0001), '0);
    chk("shr_sext", 64'hffff_ffff_8000_0001, res0[2].data);
    chk("shr_wr", 64'h1, 64'(res0[2].wr_en));
    run(sl(alu(`ISU_FN_SHR_VAR, 5'h07), 64'h1f, 64'hffff_ffff_8000_0000), '0);
    chk("shr_31", 64'h1, res0[2].data);
  endtask : t_shift

  task automatic sub1(input logic [5:0] fn, input logic [63:0] a,
                      input logic [63:0] b, input logic [63:0] d,
                      input logic w, input isu_exc_t e);
    run(sl(alu(fn, 5'h09), a, b), '0);
    if (w)
      chk("sub_data", d, res0[2].data);
    chk("sub_wr", 64'(w), 64'(res0[2].wr_en));
    chk("sub_exc", 64'(e), 64'(res0[2].exc));
  endtask : sub1

  task automatic st1(input logic bem, input logic [15:0] imm,
                     input isu_xrsp_t f, input isu_exc_t e);
    logic [63:0] va;
    logic hi;
    int cnt;
    big_endian_mode_in = bem;
    fault = f;
    va = 64'h1000 + {{48{imm[15]}}, imm};
    hi = va[2] ^ bem;
    cnt = 0;
    run(sl(swi(imm), 64'h1000, 64'hdead_beef_1234_5678), '0);
    for (int k = 0; k < 8; k++)
      cnt += int'(m0[k].wr === 1'b1);
    chk("st_exc", 64'(e), 64'(res0[2].exc));
    chk("st_wrcnt", 64'(e == EXC_NONE), 64'(cnt));
    chk("st_req", 64'(va[1:0] == 2'h0), 64'(x0[1].valid));
    if (va[1:0] == 2'h0)
      chk("st_xva", va, x0[1].vaddr);
    if (e == EXC_NONE)
    begin
      chk("st_mva", va, m0[2].vaddr);
      chk("st_data", hi ? 64'h1234_5678_0000_0000 : 64'h1234_5678,
          m0[2].data);
      chk("st_be", hi ? 64'hf0 : 64'h0f, 64'(m0[2].be));
    end
    fault = '0;
  endtask : st1

  task automatic t_ssnop();
    isu_instr_t ss;
    ss = shl0(`ISU_SSNOP_SA);
    run(sl(alu(`ISU_FN_SUB_MOD, 5'h0a), 64'h9, 64'h4), sl(ss, 64'h0, 64'h0));
    chk("split_rdy", 64'h0, 64'(rdy[0]));
    chk("split_m1", 64'h1, 64'(mk[1]));
    chk("split_m2", 64'h1, 64'(mk[2]));
    chk("split_rdy1", 64'h1, 64'(rdy[1]));
    chk("first_res", 64'h5, res0[2].data);
    chk("ssnop_v", 64'h1, 64'(res0[3].valid));
    chk("ssnop_wr", 64'h0, 64'(res0[3].wr_en));
    chk("lane1", 64'h0, 64'(res1[2].valid | res1[3].valid));
    run(sl(ss, 64'h0, 64'h0), sl(alu(`ISU_FN_SUB_MOD, 5'h0b), 64'h9, 64'h4));
    chk("lead_m1", 64'h1, 64'(mk[1]));
    chk("lead_m2", 64'h1, 64'(mk[2]));
    chk("lead_wr", 64'h0, 64'(res0[2].wr_en));
    chk("next_res", 64'h5, res0[3].data);
    chk("next_dst", 64'hb, 64'(res0[3].dst));
    run(sl(alu(`ISU_FN_SUB_MOD, 5'h0a), 64'h9, 64'h4),
        sl(shl0(5'h02), 64'h0, 64'h0));
    chk("shl2_rdy", 64'h1, 64'(rdy[0]));
    chk("shl2_mask", 64'h3, 64'(mk[1]));
    chk("shl2_v", 64'h1, 64'(res1[2].valid));
    big_endian_mode_in = 1'b0;
    run(sl(alu(`ISU_FN_SUB_MOD, 5'h0a), 64'h9, 64'h4),
        sl(swi(16'h0008), 64'h1000, 64'h0000_0000_cafe_f00d));
    chk("lane1_req", 64'h1, 64'(x1[1].valid));
    chk("lane1_va", 64'h1008, x1[1].vaddr);
    chk("lane1_wr", 64'h1, 64'(m1[2].wr));
    chk("lane1_data", 64'hcafe_f00d, m1[2].data);
    chk("lane1_be", 64'h0f, 64'(m1[2].be));
    chk("lane1_exc", 64'(EXC_NONE), 64'(res1[2].exc));
  endtask : t_ssnop

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    mclk_in = 1'b0;
    srst_in = 1'b1;
    big_endian_mode_in = 1'b0;
    group_in = '0;
    group_valid_in = 1'b0;
    fault = '0;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(negedge mclk_in);
    srst_in = 1'b0;
    chk("rst_rdy", 64'h1, 64'(group_ready_out));
    chk("rst_mask", 64'h0, 64'(issue_mask_out));
    t_shift();
    sub1(`ISU_FN_SUB, 64'h5, 64'h7, 64'hffff_ffff_ffff_fffe, 1'b1,
         EXC_NONE);
    sub1(`ISU_FN_SUB, 64'h7fff_ffff, 64'hffff_ffff_ffff_ffff, 64'h0, 1'b0,
         EXC_OVERFLOW);
    sub1(`ISU_FN_SUB, 64'hffff_ffff_8000_0000, 64'h1, 64'h0, 1'b0,
         EXC_OVERFLOW);
    sub1(`ISU_FN_SUB, 64'hffff_ffff_8000_0000, 64'h0,
         64'hffff_ffff_8000_0000, 1'b1, EXC_NONE);
    sub1(`ISU_FN_SUB_MOD, 64'h7fff_ffff, 64'hffff_ffff_ffff_ffff,
         64'hffff_ffff_8000_0000, 1'b1, EXC_NONE);
    sub1(`ISU_FN_SUB_MOD, 64'hffff_ffff_8000_0000, 64'h1, 64'h7fff_ffff,
         1'b1, EXC_NONE);
    st1(1'b0, 16'hfffc, 4'h0, EXC_NONE);
    st1(1'b1, 16'hfffc, 4'h0, EXC_NONE);
    st1(1'b0, 16'h0010, 4'h0, EXC_NONE);
    st1(1'b1, 16'h0010, 4'h0, EXC_NONE);
    st1(1'b0, 16'h0001, 4'h0, EXC_ADDR);
    st1(1'b0, 16'h0002, 4'hf, EXC_ADDR);
    st1(1'b0, 16'h0000, 4'h8, EXC_REFILL);
    st1(1'b0, 16'h0000, 4'h4, EXC_INVALID);
    st1(1'b0, 16'h0000, 4'h2, EXC_MODIFIED);
    st1(1'b0, 16'h0000, 4'h1, EXC_WATCH);
    st1(1'b1, 16'h0004, 4'hf, EXC_REFILL);
    t_ssnop();
    give_verdict();
  end

  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end

endmodule : isu_exec_tb
